// ==== include/bp_map_pkg.sv ====
// Memory map constants and region decode for the backplane bus decoder
package bp_map_pkg;

    // Region bounds in the flat 64 KB space
    localparam logic [15:0] PROG_LAST  = 16'h8fff;
    localparam logic [15:0] BOOT_LAST  = 16'h1fff;
    localparam logic [15:0] SCSI_FIRST = 16'h9000;
    localparam logic [15:0] SCSI_LAST  = 16'h9fff;
    localparam logic [15:0] PWR_FIRST  = 16'ha000;
    localparam logic [15:0] PWR_LAST   = 16'hafff;

    // Power control byte layout and reset value
    localparam logic [7:0] PWR_RESET    = 8'hdf;
    localparam int         PWR_SLOT_LSB = 0;
    localparam int         PWR_SLOT_MSB = 4;
    localparam int         PWR_IDSEL    = 5;
    localparam int         PWR_RSVD     = 6;
    localparam int         PWR_CHASSIS  = 7;

    // Pin synchroniser slots
    localparam int         PIN_COUNT   = 4;
    localparam int         PIN_JUMPER  = 0;
    localparam int         PIN_CHASSIS = 1;
    localparam int         PIN_IDSEL   = 2;
    localparam int         PIN_BPRST   = 3;
    localparam logic [3:0] PIN_RESET   = 4'h8;

    // Address regions decoded here
    typedef enum {
        REG_PROG,
        REG_SCSI,
        REG_PWR,
        REG_OTHER
    } region_type;

    // Every address falls in exactly one region
    function automatic region_type region_of(input logic [15:0] a);
        if (a <= PROG_LAST)
            return REG_PROG;
        else if (a <= SCSI_LAST)
            return REG_SCSI;
        else if (a <= PWR_LAST)
            return REG_PWR;
        else
            return REG_OTHER;
    endfunction

endpackage

// ==== rtl/backplane_memory_map_power_ctrl.sv ====
// Bus decoder, boot block guard, SCSI DMA strobes and drive power byte
module backplane_memory_map_power_ctrl #(
    parameter int SLOT_COUNT = 5
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // Controller bus, same clock domain
    input  wire logic [15:0] bus_addr,
    input  wire logic [7:0]  bus_wdata,
    input  wire logic        bus_rd_n,
    input  wire logic        bus_wr_n,
    output logic      [7:0]  bus_rdata,
    output logic             bus_rdata_valid,
    // Program memory strobes
    output logic             prog_ce_n,
    output logic             prog_oe_n,
    output logic             prog_we_n,
    // SCSI controller strobes and reset
    output logic             scsi_dma_ack_n,
    output logic             scsi_rd_n,
    output logic             scsi_wr_n,
    output logic             scsi_ctrl_reset,
    // Slot power switches
    output logic [SLOT_COUNT-1:0] slot_power_switch_bits,
    // Board pins, asynchronous
    input  wire logic        boot_write_jumper,
    input  wire logic        chassis_internal,
    input  wire logic        array_id_select_bit,
    input  wire logic        backplane_reset_n
);

    // The byte layout only holds five slot bits; refuse anything else at elaboration
    if (SLOT_COUNT < 1 || SLOT_COUNT > 5)
    begin : g_bad_slot_count
        $error("SLOT_COUNT must be 1 to 5");
    end

    // Pin synchronisers: three stages, change taken once 2 and 3 agree
    logic [3:0] sync1_q, sync1_d;
    logic [3:0] sync2_q, sync2_d;
    logic [3:0] sync3_q, sync3_d;
    logic [3:0] pin_q,   pin_d;

    always_comb
    begin
        sync1_d = {backplane_reset_n, array_id_select_bit,
                   chassis_internal, boot_write_jumper};
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        // Agreement filter rejects a single sampled glitch
        pin_d   = (sync2_q & sync3_q) | (pin_q & (sync2_q | sync3_q));
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            sync1_q <= bp_map_pkg::PIN_RESET;
            sync2_q <= bp_map_pkg::PIN_RESET;
            sync3_q <= bp_map_pkg::PIN_RESET;
            pin_q   <= bp_map_pkg::PIN_RESET;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            pin_q   <= pin_d;
        end
    end

    logic jumper_write;
    logic bp_reset_active;
    assign jumper_write    = pin_q[bp_map_pkg::PIN_JUMPER];
    assign bp_reset_active = !pin_q[bp_map_pkg::PIN_BPRST];

    // Decode of the live cycle
    bp_map_pkg::region_type cur_region;
    logic rd_act;
    logic wr_act;
    logic in_boot;
    assign cur_region = bp_map_pkg::region_of(bus_addr);
    assign rd_act     = !bus_rd_n;
    assign wr_act     = !bus_wr_n;
    assign in_boot    = bus_addr <= bp_map_pkg::BOOT_LAST;

    // Write tracking: address and data follow the bus while the strobe is low, held once it rises
    logic        wr_prev_q, wr_prev_d;
    logic [15:0] wr_addr_q, wr_addr_d;
    logic [7:0]  wr_data_q, wr_data_d;
    logic        commit;
    logic [4:0]  power_q,   power_d;

    always_comb
    begin
        wr_prev_d = wr_act;
        wr_addr_d = wr_act ? bus_addr  : wr_addr_q;
        wr_data_d = wr_act ? bus_wdata : wr_data_q;
        // Strobe just released on an aliased power address
        commit = wr_prev_q && !wr_act
              && bp_map_pkg::region_of(wr_addr_q) == bp_map_pkg::REG_PWR;
        power_d = power_q;
        if (commit)
            power_d = wr_data_q[4:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            wr_prev_q <= 1'b0;
            wr_addr_q <= 16'h0000;
            wr_data_q <= 8'h00;
            power_q   <= bp_map_pkg::PWR_RESET[4:0];
        end
        else
        begin
            wr_prev_q <= wr_prev_d;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            power_q   <= power_d;
        end
    end

    // Readback byte; slot bits are the commanded state only
    logic [7:0] pwr_byte;
    always_comb
    begin
        pwr_byte = 8'h00;
        pwr_byte[bp_map_pkg::PWR_SLOT_MSB:bp_map_pkg::PWR_SLOT_LSB] = power_q;
        pwr_byte[bp_map_pkg::PWR_IDSEL]   = pin_q[bp_map_pkg::PIN_IDSEL];
        // Reserved bit reads as in the default byte so a fresh read matches it
        pwr_byte[bp_map_pkg::PWR_RSVD]    = bp_map_pkg::PWR_RESET[bp_map_pkg::PWR_RSVD];
        pwr_byte[bp_map_pkg::PWR_CHASSIS] = pin_q[bp_map_pkg::PIN_CHASSIS];
    end

    // Output stage: every strobe registered, one cycle behind the bus
    logic [7:0] rdata_q, rdata_d;
    logic       rvalid_q, rvalid_d;
    logic       prog_ce_q, prog_ce_d;
    logic       prog_oe_q, prog_oe_d;
    logic       prog_we_q, prog_we_d;
    logic       dack_q, dack_d;
    logic       srd_q, srd_d;
    logic       swr_q, swr_d;
    logic       srst_q, srst_d;
    logic [SLOT_COUNT-1:0] slots_q, slots_d;

    always_comb
    begin
        prog_ce_d = !(cur_region == bp_map_pkg::REG_PROG && (rd_act || wr_act));
        prog_oe_d = !(cur_region == bp_map_pkg::REG_PROG && rd_act);
        // Boot block write without the jumper gets chip enable but no write strobe
        prog_we_d = !(cur_region == bp_map_pkg::REG_PROG && wr_act
                      && (!in_boot || jumper_write));
        dack_d = !(cur_region == bp_map_pkg::REG_SCSI && (rd_act || wr_act));
        srd_d  = !(cur_region == bp_map_pkg::REG_SCSI && rd_act);
        swr_d  = !(cur_region == bp_map_pkg::REG_SCSI && wr_act);
        rvalid_d = cur_region == bp_map_pkg::REG_PWR && rd_act;
        rdata_d  = rvalid_d ? pwr_byte : 8'h00;
        srst_d   = bp_reset_active;
        // Driven from the next value so the switch follows the capture edge
        slots_d  = power_d[SLOT_COUNT-1:0];
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            rdata_q   <= 8'h00;
            rvalid_q  <= 1'b0;
            prog_ce_q <= 1'b1;
            prog_oe_q <= 1'b1;
            prog_we_q <= 1'b1;
            dack_q    <= 1'b1;
            srd_q     <= 1'b1;
            swr_q     <= 1'b1;
            srst_q    <= 1'b1;
            slots_q   <= bp_map_pkg::PWR_RESET[SLOT_COUNT-1:0];
        end
        else
        begin
            rdata_q   <= rdata_d;
            rvalid_q  <= rvalid_d;
            prog_ce_q <= prog_ce_d;
            prog_oe_q <= prog_oe_d;
            prog_we_q <= prog_we_d;
            dack_q    <= dack_d;
            srd_q     <= srd_d;
            swr_q     <= swr_d;
            srst_q    <= srst_d;
            slots_q   <= slots_d;
        end
    end

    assign bus_rdata              = rdata_q;
    assign bus_rdata_valid        = rvalid_q;
    assign prog_ce_n              = prog_ce_q;
    assign prog_oe_n              = prog_oe_q;
    assign prog_we_n              = prog_we_q;
    assign scsi_dma_ack_n         = dack_q;
    assign scsi_rd_n              = srd_q;
    assign scsi_wr_n              = swr_q;
    assign scsi_ctrl_reset        = srst_q;
    assign slot_power_switch_bits = slots_q;

    // Boot block protected: no write strobe follows
    property p_boot_guard;
        @(posedge clk) disable iff (!rstn)
        (wr_act && in_boot && !jumper_write) |=> prog_we_n;
    endproperty
    a_boot_guard: assert property (p_boot_guard)
        else $error("boot block written while protected");

    // Ordinary program write reaches the memory next cycle
    property p_prog_write;
        @(posedge clk) disable iff (!rstn)
        (wr_act && cur_region == bp_map_pkg::REG_PROG && !in_boot)
            |=> !prog_we_n && !prog_ce_n;
    endproperty
    a_prog_write: assert property (p_prog_write)
        else $error("program write strobe missing");

    // DMA window read gives acknowledge and read strobe only
    property p_dma_read;
        @(posedge clk) disable iff (!rstn)
        (rd_act && !wr_act && cur_region == bp_map_pkg::REG_SCSI)
            |=> !scsi_dma_ack_n && !scsi_rd_n && scsi_wr_n;
    endproperty
    a_dma_read: assert property (p_dma_read)
        else $error("DMA read strobes wrong");

    // Acknowledge never shown outside the DMA window
    property p_dma_only;
        @(posedge clk) disable iff (!rstn)
        !scsi_dma_ack_n |-> $past(cur_region) == bp_map_pkg::REG_SCSI;
    endproperty
    a_dma_only: assert property (p_dma_only)
        else $error("acknowledge outside DMA window");

    // Aliased read returns the commanded byte
    property p_pwr_read;
        @(posedge clk) disable iff (!rstn)
        (rd_act && cur_region == bp_map_pkg::REG_PWR)
            |=> bus_rdata_valid && bus_rdata[4:0] == $past(power_q)
                && bus_rdata[bp_map_pkg::PWR_RSVD] == bp_map_pkg::PWR_RESET[bp_map_pkg::PWR_RSVD];
    endproperty
    a_pwr_read: assert property (p_pwr_read)
        else $error("power byte readback wrong");

    // Status bits follow their pins
    property p_status_bits;
        @(posedge clk) disable iff (!rstn)
        bus_rdata_valid |-> bus_rdata[7] == $past(pin_q[1]) && bus_rdata[5] == $past(pin_q[2]);
    endproperty
    a_status_bits: assert property (p_status_bits)
        else $error("status bits wrong");

    // Strobe release captures data and switches slots on that edge
    property p_capture;
        @(posedge clk) disable iff (!rstn)
        commit |=> slot_power_switch_bits == $past(wr_data_q[SLOT_COUNT-1:0]);
    endproperty
    a_capture: assert property (p_capture)
        else $error("power byte not captured");

    // Without a finished write the slots hold
    property p_hold;
        @(posedge clk) disable iff (!rstn)
        !commit ##1 !commit |-> $stable(slot_power_switch_bits);
    endproperty
    a_hold: assert property (p_hold)
        else $error("slot power changed without write");

    // Reset leaves all slots powered
    property p_reset_on;
        @(posedge clk)
        !rstn |=> slot_power_switch_bits == bp_map_pkg::PWR_RESET[SLOT_COUNT-1:0] && scsi_ctrl_reset;
    endproperty
    a_reset_on: assert property (p_reset_on)
        else $error("reset state wrong");

    // Backplane reset drives the SCSI reset
    property p_scsi_reset;
        @(posedge clk) disable iff (!rstn)
        bp_reset_active |=> scsi_ctrl_reset;
    endproperty
    a_scsi_reset: assert property (p_scsi_reset)
        else $error("SCSI reset missing");

endmodule

// ==== verif/bus_master_model.sv ====
// Controller bus master model driving the decoder's external bus
module bus_master_model (
    // Clock
    input  wire logic        clk,
    // Bus toward the decoder
    output logic      [15:0] bus_addr,
    output logic      [7:0]  bus_wdata,
    output logic             bus_rd_n,
    output logic             bus_wr_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus with both strobes high
    initial
    begin
        bus_addr  = 16'hffff;
        bus_wdata = 8'hff;
        bus_rd_n  = 1'b1;
        bus_wr_n  = 1'b1;
    end

    // Opens one cycle; closing it is left to the caller
    task automatic open_cycle(input logic [15:0] a, input logic [7:0] d, input logic wr);
        bus_addr  = a;
        bus_wdata = d;
        bus_rd_n  = wr;
        bus_wr_n  = !wr;
    endtask

    // Released lines show the inverse so stale values never match by luck
    task automatic close_cycle();
        bus_rd_n  = 1'b1;
        bus_wr_n  = 1'b1;
        bus_addr  = ~bus_addr;
        bus_wdata = ~bus_wdata;
    endtask
endmodule

// ==== verif/tb_backplane_memory_map_power_ctrl.sv ====
// Self-checking bench for the bus decoder and drive power byte
module tb_backplane_memory_map_power_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CEILING = 3000;
    localparam logic [15:0] ADDRS [8] = '{16'h0000, 16'h8fff, 16'h1fff, 16'h1fff,
                                          16'h2000, 16'h9000, 16'h9fff, 16'hb000};
    localparam logic [7:0]  WRS   = 8'b0101_1110;
    localparam logic [7:0]  JMPS  = 8'b0000_1000;
    // Expected {ce, oe, we, ack, rd, wr} per table entry
    localparam logic [5:0]  EXPS [8] = '{6'b001111, 6'b010111, 6'b011111, 6'b010111,
                                         6'b010111, 6'b111001, 6'b111010, 6'b111111};

    logic        clk, rstn, bus_rd_n, bus_wr_n, bus_rdata_valid;
    logic [15:0] bus_addr;
    logic [7:0]  bus_wdata, bus_rdata, s_rdata, s_mid;
    logic        prog_ce_n, prog_oe_n, prog_we_n, scsi_dma_ack_n, scsi_rd_n, scsi_wr_n, scsi_ctrl_reset;
    logic [4:0]  slot_power_switch_bits;
    logic        boot_write_jumper, chassis_internal, array_id_select_bit, backplane_reset_n;
    logic [5:0]  s_strobes;
    logic        s_valid;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;

    backplane_memory_map_power_ctrl u_backplane_memory_map_power_ctrl (
        .clk(clk), .rstn(rstn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_rdata(bus_rdata),
        .bus_rdata_valid(bus_rdata_valid), .prog_ce_n(prog_ce_n), .prog_oe_n(prog_oe_n),
        .prog_we_n(prog_we_n), .scsi_dma_ack_n(scsi_dma_ack_n), .scsi_rd_n(scsi_rd_n),
        .scsi_wr_n(scsi_wr_n), .scsi_ctrl_reset(scsi_ctrl_reset),
        .slot_power_switch_bits(slot_power_switch_bits), .boot_write_jumper(boot_write_jumper),
        .chassis_internal(chassis_internal), .array_id_select_bit(array_id_select_bit),
        .backplane_reset_n(backplane_reset_n));

    bus_master_model u_bus_master_model (
        .clk(clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n));

    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
    end
    always #12.5 clk = ~clk;

    // Hang guard: runs out far beyond the expected length of the tests
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == CEILING)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One bus cycle; strobes and read data are taken one edge after the strobe
    task automatic access(input logic [15:0] a, input logic [7:0] d, input logic wr);
        u_bus_master_model.open_cycle(a, d, wr);
        @(posedge clk);
        #1;
        u_bus_master_model.close_cycle();
        s_strobes = {prog_ce_n, prog_oe_n, prog_we_n, scsi_dma_ack_n, scsi_rd_n, scsi_wr_n};
        s_valid   = bus_rdata_valid;
        s_rdata   = bus_rdata;
        s_mid     = {3'b000, slot_power_switch_bits};
        @(posedge clk);
        #1;
    endtask

    task automatic rd_pwr(input logic [15:0] a, input logic [7:0] exp);
        access(a, 8'h00, 1'b0);
        check({7'h00, s_valid}, 8'h01);
        check(s_rdata, exp);
    endtask

    // Pins move asynchronously; six cycles cover the synchroniser
    task automatic settle();
        repeat (6) @(posedge clk);
        #1;
    endtask

    initial
    begin
        rstn = 1'b0;
        boot_write_jumper = 1'b0;
        chassis_internal = 1'b1;
        array_id_select_bit = 1'b0;
        backplane_reset_n = 1'b1;
        settle();
        check({7'h00, scsi_ctrl_reset}, 8'h01);
        check({3'b000, slot_power_switch_bits}, 8'h1f);
        rstn = 1'b1;
        settle();
        check({7'h00, scsi_ctrl_reset}, 8'h00);
        rd_pwr(16'ha000, 8'hdf);
        // Aliased write; zeros in the upper bits must not stick
        access(16'hafff, 8'h0a, 1'b1);
        check(s_mid, 8'h1f);
        check({3'b000, slot_power_switch_bits}, 8'h0a);
        rd_pwr(16'ha555, 8'hca);
        access(16'ha000, 8'hff, 1'b1);
        rd_pwr(16'ha7ff, 8'hdf);
        chassis_internal = 1'b0;
        array_id_select_bit = 1'b1;
        settle();
        rd_pwr(16'ha001, 8'h7f);
        access(16'haffe, 8'h15, 1'b1);
        rd_pwr(16'ha800, 8'h75);
        access(16'ha000, 8'h1f, 1'b1);
        // Region strobes, boot block guard and untouched power byte
        for (int i = 0; i < 8; i++)
        begin
            boot_write_jumper = JMPS[i];
            settle();
            access(ADDRS[i], 8'h00, WRS[i]);
            check({2'b00, s_strobes}, {2'b00, EXPS[i]});
            check({3'b000, slot_power_switch_bits}, 8'h1f);
        end
        access(16'hb000, 8'h00, 1'b0);
        check({7'h00, s_valid}, 8'h00);
        check(s_rdata, 8'h00);
        backplane_reset_n = 1'b0;
        settle();
        check({7'h00, scsi_ctrl_reset}, 8'h01);
        backplane_reset_n = 1'b1;
        settle();
        check({7'h00, scsi_ctrl_reset}, 8'h00);
        // Second reset in mid-run brings every slot back on
        access(16'ha000, 8'h00, 1'b1);
        check({3'b000, slot_power_switch_bits}, 8'h00);
        rstn = 1'b0;
        settle();
        rstn = 1'b1;
        @(posedge clk);
        #1;
        check({3'b000, slot_power_switch_bits}, 8'h1f);
        wrap_up();
    end
endmodule
